// >>> dbc_addr_mux.sv
// Row and column address multiplexer for the DRAM address lines
`timescale 1ns/1ps
`default_nettype none

module dbc_addr_mux (
	input wire logic [23:0] addr_w,
	input wire logic [3:0] rows,
	input wire logic [3:0] cols,
	input wire logic word_ilv,
	input wire logic page_ilv,
	input wire logic row_phase,
	output logic [11:0] ma
);
	logic [23:0] col_src;
	logic [23:0] row_src;
	logic [11:0] col_mask;
	logic [11:0] row_mask;
	logic [4:0] row_shift;

	// The interleave select bit is skipped so both banks see one linear map
	always_comb begin
		row_shift = {1'b0, cols} + {4'h0, page_ilv | word_ilv};
		col_src = word_ilv ? (addr_w >> 1) : addr_w;
		row_src = addr_w >> row_shift;
		col_mask = 12'hfff >> (5'h0c - {1'b0, cols});
		row_mask = 12'hfff >> (5'h0c - {1'b0, rows});
		if (row_phase) begin
			ma = row_src[11:0] & row_mask;
		end else begin
			ma = col_src[11:0] & col_mask;
		end
	end

endmodule
`default_nettype wire

// >>> dbc_dram_model.sv
// Behavioural DRAM array that records the row and column it is strobed with
`timescale 1ns/1ps
`default_nettype none

module dbc_dram_model (
	input wire logic clock,
	input wire logic [7:0] ras_n,
	input wire logic cas_n,
	input wire logic [11:0] ma,
	output logic [11:0] row_seen,
	output logic [11:0] col_seen,
	output logic cas_without_ras
);
	logic ras_prev = 1'b1;
	logic cas_prev = 1'b1;

	initial begin
		row_seen = 12'h000;
		col_seen = 12'h000;
		cas_without_ras = 1'b0;
	end

	// ==========================================
	// Strobe capture
	// Sampled one edge late so the address is taken as it stood under the strobe
	always @(posedge clock) begin
		if (ras_prev && (&ras_n) === 1'b0) row_seen <= ma;
		if (cas_prev && cas_n === 1'b0) col_seen <= ma;
		// A column strobe with no bank open would corrupt the array
		if (cas_n === 1'b0 && (&ras_n) === 1'b1) cas_without_ras <= 1'b1;
		ras_prev <= &ras_n;
		cas_prev <= cas_n;
	end
endmodule
`default_nettype wire

// >>> dbc_pkg.sv
// Shared constants, types and geometry function for the DRAM bank configuration block
package dbc_pkg;

	// ==========================================
	// I/O port offsets
	localparam logic [15:0] OFS_MEM_CTRL = 16'h3872;
	localparam logic [15:0] OFS_START_B1 = 16'h4872;
	localparam logic [15:0] OFS_START_B3 = 16'h5072;
	localparam logic [15:0] OFS_START_B5 = 16'h2c72;
	localparam logic [15:0] OFS_START_B7 = 16'h3472;
	localparam logic [15:0] OFS_SIZE_EXT = 16'h7472;

	// ==========================================
	// Field positions and reset values
	localparam int POS_STROBE_W = 15;
	localparam int POS_ILV_U_ODD = 14;
	localparam int POS_CACHE = 12;
	localparam int POS_PAGE = 11;
	localparam int POS_ILV_U_EVEN = 10;
	localparam int POS_ILV_L_ODD = 9;
	localparam int POS_ILV_L_EVEN = 8;
	localparam int POS_EN_UPPER = 4;
	localparam int POS_SIZE_UPPER = 2;
	localparam int POS_SIZE_LOWER = 0;
	localparam int POS_EXT_UPPER = 13;
	localparam int POS_EXT_LOWER = 12;
	localparam logic [15:0] RST_MEM_CTRL = 16'h0000;
	localparam logic [7:0] RST_START = 8'h00;
	localparam logic [1:0] RST_EXT = 2'h0;

	// ==========================================
	// Timing and address constants
	localparam logic [1:0] CAS_CYCLES = 2'h2;
	localparam logic [24:0] LOW_MEM_END = 25'h0a0000;
	localparam logic [24:0] LOW_DIS_128K = 25'h020000;
	localparam logic [24:0] LOW_DIS_256K = 25'h040000;
	localparam logic [24:0] LOW_DIS_512K = 25'h080000;

	typedef enum logic [1:0] {
		DBC_CA_NONE = 2'b00,
		DBC_CA_EXT = 2'b01,
		DBC_CA_EMC = 2'b10,
		DBC_CA_ALT = 2'b11
	} dbc_cache_t;

	typedef struct packed {
		logic [3:0] rows;
		logic [3:0] cols;
		logic [2:0] span;
		logic valid;
	} dbc_geom_t;

	typedef struct packed {
		logic [7:0] b6;
		logic [7:0] b4;
		logic [7:0] b2;
		logic [7:0] b0;
	} dbc_even_start_t;

	// Matrix and region span (log2 of size over 128 Kbyte) per size code
	function automatic dbc_geom_t dbc_geom(input logic ext, input logic [1:0] code);
		dbc_geom_t g;
		g = '{rows: 4'h0, cols: 4'h0, span: 3'h0, valid: 1'b1};
		case ({ext, code})
			3'h0: g = '{rows: 4'h8, cols: 4'h8, span: 3'h0, valid: 1'b1};
			3'h1: g = '{rows: 4'h9, cols: 4'h9, span: 3'h2, valid: 1'b1};
			3'h2: g = '{rows: 4'ha, cols: 4'ha, span: 3'h4, valid: 1'b1};
			3'h3: g = '{rows: 4'hc, cols: 4'hb, span: 3'h6, valid: 1'b1};
			3'h4: g = '{rows: 4'ha, cols: 4'h9, span: 3'h3, valid: 1'b1};
			3'h5: g = '{rows: 4'hc, cols: 4'h8, span: 3'h4, valid: 1'b1};
			3'h6: g = '{rows: 4'hb, cols: 4'ha, span: 3'h5, valid: 1'b1};
			default: g.valid = 1'b0;
		endcase
		return g;
	endfunction

endpackage

// >>> dbc_top.sv
// DRAM bank configuration, bank decode and strobe control
// ==========================================
// Summary of operation
// - Drive row then column on address lines
// - I/O cycles output five-bit chip select code
// - Low eight lines carry peripheral data
// - Withhold CAS on protected memory writes
// - Disable low memory from 128/256/512K to 640K
// - Strobe width bit: reads 2.5 or 2 clocks, writes 2
// - Four bits interleave four bank pairs
// - Cache mode adds one read wait state
// - Cache mode changes after hold acknowledge
// - Cache mode selects shared pin function
// - Page bit clear: non-page, word interleave
// - Page bit set: PAGE_MODE output set, page interleave
// - Bits 7:4 enable banks 7:4, reset 0
// - Two size groups, each with extension bit
// - Extension clear: four standard part sizes
// - Extension set: three sizes, one reserved
// - Interleaved pair is one double region
`timescale 1ns/1ps
`default_nettype none

module dbc_top (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [15:0] IO_WDATA,
	output logic [15:0] IO_RDATA,
	output logic IO_HIT,
	input wire logic [3:0] LOWER_BANK_ENABLE,
	input wire dbc_pkg::dbc_even_start_t EVEN_BANK_START,
	input wire logic [1:0] LOW_DISABLE_SEL,
	input wire logic HOLD_ACK,
	input wire logic [24:0] CPU_ADDR,
	input wire logic MEM_REQ,
	input wire logic MEM_READ,
	input wire logic WRITE_PROTECT_ZONE,
	input wire logic MEMORY_WRITE_STROBE_N,
	input wire logic IO_CYCLE,
	input wire logic [4:0] CHIP_SEL_CODE,
	input wire logic PERIPH_WRITE,
	input wire logic [7:0] PERIPH_WDATA,
	output logic [7:0] PERIPH_RDATA,
	input wire logic [11:0] MA_IN,
	output logic [11:0] MA_OUT,
	output logic [11:0] MA_OE,
	output logic DEC_HI,
	output logic DEC_LO,
	output logic [7:0] RAS_N,
	output logic CAS_N,
	output logic CAS_HALF_EXTEND,
	output logic MEM_ACK,
	output logic MEM_MISS,
	output logic PAGE_MODE,
	output logic [1:0] CACHE_MODE,
	output logic ALT_CLOCK_ALLOWED,
	output logic PARITY_PIN_INPUT
);
	typedef enum logic [1:0] {
		DBC_S_IDLE = 2'b00,
		DBC_S_ROW = 2'b01,
		DBC_S_WAIT = 2'b10,
		DBC_S_CAS = 2'b11
	} dbc_state_t;

	// ==========================================
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [1:0] memory_write_strobe_sync_reg;
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			memory_write_strobe_sync_reg <= 2'h3;
			pin_s1_reg <= 8'h00;
			pin_s2_reg <= 8'h00;
		end else begin
			memory_write_strobe_sync_reg <= {memory_write_strobe_sync_reg[0], MEMORY_WRITE_STROBE_N};
			pin_s1_reg <= MA_IN[7:0];
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// ==========================================
	// Registers
	logic [15:0] mem_ctrl_reg, mem_ctrl_next;
	logic [7:0] start1_reg, start1_next;
	logic [7:0] start3_reg, start3_next;
	logic [7:0] start5_reg, start5_next;
	logic [7:0] start7_reg, start7_next;
	logic [1:0] ext_reg, ext_next;
	logic [1:0] cache_act_reg, cache_act_next;
	logic [15:0] rdata_reg, rdata_next;
	logic hit_reg, hit_next;

	always_comb begin
		mem_ctrl_next = mem_ctrl_reg;
		start1_next = start1_reg;
		start3_next = start3_reg;
		start5_next = start5_reg;
		start7_next = start7_reg;
		ext_next = ext_reg;
		rdata_next = 16'h0000;
		hit_next = 1'b0;
		if (IO_WR) begin
			case (IO_ADDR)
				dbc_pkg::OFS_MEM_CTRL: mem_ctrl_next = IO_WDATA;
				dbc_pkg::OFS_START_B1: start1_next = IO_WDATA[15:8];
				dbc_pkg::OFS_START_B3: start3_next = IO_WDATA[15:8];
				dbc_pkg::OFS_START_B5: start5_next = IO_WDATA[15:8];
				dbc_pkg::OFS_START_B7: start7_next = IO_WDATA[15:8];
				dbc_pkg::OFS_SIZE_EXT: begin
					ext_next = {IO_WDATA[dbc_pkg::POS_EXT_UPPER],
						IO_WDATA[dbc_pkg::POS_EXT_LOWER]};
				end
				default: ;
			endcase
		end
		if (IO_RD || IO_WR) begin
			hit_next = 1'b1;
			case (IO_ADDR)
				dbc_pkg::OFS_MEM_CTRL: rdata_next = mem_ctrl_reg;
				dbc_pkg::OFS_START_B1: rdata_next = {start1_reg, 8'h00};
				dbc_pkg::OFS_START_B3: rdata_next = {start3_reg, 8'h00};
				dbc_pkg::OFS_START_B5: rdata_next = {start5_reg, 8'h00};
				dbc_pkg::OFS_START_B7: rdata_next = {start7_reg, 8'h00};
				dbc_pkg::OFS_SIZE_EXT: rdata_next = {2'h0, ext_reg, 12'h000};
				default: hit_next = 1'b0;
			endcase
			if (!IO_RD) begin
				rdata_next = 16'h0000;
			end
		end
		// Readback shows the written cache field; the live copy waits for hold
		cache_act_next = cache_act_reg;
		if (HOLD_ACK) begin
			cache_act_next = mem_ctrl_reg[dbc_pkg::POS_CACHE +: 2];
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			mem_ctrl_reg <= dbc_pkg::RST_MEM_CTRL;
			start1_reg <= dbc_pkg::RST_START;
			start3_reg <= dbc_pkg::RST_START;
			start5_reg <= dbc_pkg::RST_START;
			start7_reg <= dbc_pkg::RST_START;
			ext_reg <= dbc_pkg::RST_EXT;
			cache_act_reg <= 2'h0;
			rdata_reg <= 16'h0000;
			hit_reg <= 1'b0;
		end else begin
			mem_ctrl_reg <= mem_ctrl_next;
			start1_reg <= start1_next;
			start3_reg <= start3_next;
			start5_reg <= start5_next;
			start7_reg <= start7_next;
			ext_reg <= ext_next;
			cache_act_reg <= cache_act_next;
			rdata_reg <= rdata_next;
			hit_reg <= hit_next;
		end
	end

	// ==========================================
	// Bank decode
	dbc_pkg::dbc_geom_t geom_lo, geom_hi, geom_sel;
	logic [7:0] bank_en;
	logic [7:0] bank_ilv;
	logic [7:0][7:0] bank_start;
	logic [7:0] bank_hit;
	logic [2:0] bank_idx;
	logic any_hit;
	logic low_dis;
	logic page_mode;
	logic [4:0] sel_bit;
	logic [24:0] dis_base;

	always_comb begin
		page_mode = mem_ctrl_reg[dbc_pkg::POS_PAGE];
		geom_lo = dbc_pkg::dbc_geom(ext_reg[0],
			mem_ctrl_reg[dbc_pkg::POS_SIZE_LOWER +: 2]);
		geom_hi = dbc_pkg::dbc_geom(ext_reg[1],
			mem_ctrl_reg[dbc_pkg::POS_SIZE_UPPER +: 2]);
		bank_en = {mem_ctrl_reg[dbc_pkg::POS_EN_UPPER +: 4], LOWER_BANK_ENABLE};
		bank_ilv[0] = mem_ctrl_reg[dbc_pkg::POS_ILV_L_EVEN];
		bank_ilv[2] = bank_ilv[0];
		bank_ilv[1] = mem_ctrl_reg[dbc_pkg::POS_ILV_L_ODD];
		bank_ilv[3] = bank_ilv[1];
		bank_ilv[4] = mem_ctrl_reg[dbc_pkg::POS_ILV_U_EVEN];
		bank_ilv[6] = bank_ilv[4];
		bank_ilv[5] = mem_ctrl_reg[dbc_pkg::POS_ILV_U_ODD];
		bank_ilv[7] = bank_ilv[5];
		bank_start = {start7_reg, EVEN_BANK_START.b6, start5_reg, EVEN_BANK_START.b4,
			start3_reg, EVEN_BANK_START.b2, start1_reg, EVEN_BANK_START.b0};
		case (LOW_DISABLE_SEL)
			2'h1: dis_base = dbc_pkg::LOW_DIS_128K;
			2'h2: dis_base = dbc_pkg::LOW_DIS_256K;
			2'h3: dis_base = dbc_pkg::LOW_DIS_512K;
			default: dis_base = dbc_pkg::LOW_MEM_END;
		endcase
		low_dis = (CPU_ADDR >= dis_base) && (CPU_ADDR < dbc_pkg::LOW_MEM_END);
		// Select bit: page-size bit in page mode, word bit otherwise
		sel_bit = 5'h1;
		if (page_mode) begin
			sel_bit = {1'b0, geom_lo.cols} + 5'h1;
		end
		for (int b = 0; b < 8; b++) begin
			geom_sel = (b >= 4) ? geom_hi : geom_lo;
			if (page_mode && b >= 4) begin
				sel_bit = {1'b0, geom_hi.cols} + 5'h1;
			end
			// Pair spans twice the bank and splits on the select bit
			bank_hit[b] = bank_en[b] && geom_sel.valid && !low_dis &&
				(((CPU_ADDR[24:17] ^ bank_start[b]) &
				(8'hff << (geom_sel.span + {2'h0, bank_ilv[b]}))) == 8'h00) &&
				(!bank_ilv[b] || (CPU_ADDR[sel_bit] == ((b % 4) >= 2)));
		end
		any_hit = |bank_hit;
		bank_idx = 3'h0;
		for (int b = 7; b >= 0; b--) begin
			if (bank_hit[b]) begin
				bank_idx = 3'(b);
			end
		end
	end

	// ==========================================
	// Address multiplexer
	logic [11:0] mux_ma;
	dbc_state_t state_reg, state_next;
	logic cur_ilv_reg, cur_ilv_next;
	logic [2:0] cur_bank_reg, cur_bank_next;
	logic cur_read_reg, cur_read_next;
	dbc_pkg::dbc_geom_t cur_geom;

	always_comb begin
		cur_geom = cur_bank_reg[2] ? geom_hi : geom_lo;
	end

	dbc_addr_mux u_mux (
		.addr_w(CPU_ADDR[24:1]),
		.rows(cur_geom.rows),
		.cols(cur_geom.cols),
		.word_ilv(cur_ilv_reg && !page_mode),
		.page_ilv(cur_ilv_reg && page_mode),
		.row_phase(state_reg == DBC_S_ROW),
		.ma(mux_ma)
	);

	// ==========================================
	// Cycle sequencer
	logic [1:0] cas_cnt_reg, cas_cnt_next;
	logic [11:0] ma_next, oe_next;
	logic [7:0] ras_next;
	logic cas_next, half_next, ack_next, miss_next, dhi_next, dlo_next;
	logic wp_block;
	logic cache_on;

	always_comb begin
		cache_on = cache_act_reg != dbc_pkg::DBC_CA_NONE;
		wp_block = WRITE_PROTECT_ZONE && !memory_write_strobe_sync_reg[1] && !cur_read_reg;
		state_next = state_reg;
		cas_cnt_next = cas_cnt_reg;
		cur_bank_next = cur_bank_reg;
		cur_ilv_next = cur_ilv_reg;
		cur_read_next = cur_read_reg;
		ma_next = 12'h000;
		oe_next = 12'h000;
		ras_next = 8'hff;
		cas_next = 1'b1;
		half_next = 1'b0;
		ack_next = 1'b0;
		miss_next = 1'b0;
		dhi_next = 1'b0;
		dlo_next = 1'b0;
		case (state_reg)
			DBC_S_IDLE: begin
				if (MEM_REQ && any_hit) begin
					state_next = DBC_S_ROW;
					cur_bank_next = bank_idx;
					cur_ilv_next = bank_ilv[bank_idx];
					cur_read_next = MEM_READ;
				end else if (MEM_REQ) begin
					miss_next = 1'b1;
				end else if (IO_CYCLE) begin
					ma_next[10:8] = CHIP_SEL_CODE[4:2];
					dhi_next = CHIP_SEL_CODE[1];
					dlo_next = CHIP_SEL_CODE[0];
					oe_next[10:8] = 3'h7;
					if (PERIPH_WRITE) begin
						ma_next[7:0] = PERIPH_WDATA;
						oe_next[7:0] = 8'hff;
					end
				end
			end
			DBC_S_ROW: begin
				ma_next = mux_ma;
				oe_next = 12'hfff;
				ras_next[cur_bank_reg] = 1'b0;
				cas_cnt_next = dbc_pkg::CAS_CYCLES;
				if (cur_read_reg && cache_on) begin
					state_next = DBC_S_WAIT;
				end else begin
					state_next = DBC_S_CAS;
				end
			end
			DBC_S_WAIT: begin
				ma_next = mux_ma;
				oe_next = 12'hfff;
				ras_next[cur_bank_reg] = 1'b0;
				state_next = DBC_S_CAS;
			end
			DBC_S_CAS: begin
				ma_next = mux_ma;
				oe_next = 12'hfff;
				ras_next[cur_bank_reg] = 1'b0;
				cas_next = wp_block;
				cas_cnt_next = cas_cnt_reg - 2'h1;
				// Pad logic stretches the last read cycle by half a clock
				half_next = cur_read_reg && (cas_cnt_reg == 2'h1) &&
					!mem_ctrl_reg[dbc_pkg::POS_STROBE_W];
				if (cas_cnt_reg == 2'h1) begin
					state_next = DBC_S_IDLE;
					ack_next = 1'b1;
				end
			end
			default: state_next = DBC_S_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DBC_S_IDLE;
			cas_cnt_reg <= 2'h0;
			cur_bank_reg <= 3'h0;
			cur_ilv_reg <= 1'b0;
			cur_read_reg <= 1'b0;
			MA_OUT <= 12'h000;
			MA_OE <= 12'h000;
			RAS_N <= 8'hff;
			CAS_N <= 1'b1;
			CAS_HALF_EXTEND <= 1'b0;
			MEM_ACK <= 1'b0;
			MEM_MISS <= 1'b0;
			DEC_HI <= 1'b0;
			DEC_LO <= 1'b0;
		end else begin
			state_reg <= state_next;
			cas_cnt_reg <= cas_cnt_next;
			cur_bank_reg <= cur_bank_next;
			cur_ilv_reg <= cur_ilv_next;
			cur_read_reg <= cur_read_next;
			MA_OUT <= ma_next;
			MA_OE <= oe_next;
			RAS_N <= ras_next;
			CAS_N <= cas_next;
			CAS_HALF_EXTEND <= half_next;
			MEM_ACK <= ack_next;
			MEM_MISS <= miss_next;
			DEC_HI <= dhi_next;
			DEC_LO <= dlo_next;
		end
	end

	// ==========================================
	// Status outputs
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			PAGE_MODE <= 1'b0;
			CACHE_MODE <= 2'h0;
			ALT_CLOCK_ALLOWED <= 1'b1;
			PARITY_PIN_INPUT <= 1'b0;
			PERIPH_RDATA <= 8'h00;
		end else begin
			PAGE_MODE <= page_mode;
			CACHE_MODE <= cache_act_reg;
			ALT_CLOCK_ALLOWED <= cache_act_reg == dbc_pkg::DBC_CA_NONE ||
				cache_act_reg == dbc_pkg::DBC_CA_ALT;
			PARITY_PIN_INPUT <= cache_act_reg == dbc_pkg::DBC_CA_EMC;
			PERIPH_RDATA <= pin_s2_reg;
		end
	end

	assign IO_RDATA = rdata_reg;
	assign IO_HIT = hit_reg;

	// ==========================================
	// Checks
	a_ctrl_reset_zero: assert property (@(posedge CLOCK)
		$rose(rst_n) |-> mem_ctrl_reg == 16'h0000)
		else $error("memory control not zero after reset");

	a_cache_waits_hold: assert property (@(posedge CLOCK) disable iff (!rst_n)
		!$past(HOLD_ACK) |-> $stable(cache_act_reg))
		else $error("cache mode changed without hold acknowledge");

	a_read_wait_state: assert property (@(posedge CLOCK) disable iff (!rst_n)
		state_reg == DBC_S_ROW && cur_read_reg && cache_on |=> state_reg == DBC_S_WAIT)
		else $error("missing cache read wait state");

	a_no_wait_plain: assert property (@(posedge CLOCK) disable iff (!rst_n)
		state_reg == DBC_S_ROW && !cache_on |=> state_reg == DBC_S_CAS)
		else $error("extra wait state without cache mode");

	a_cas_two_cycles: assert property (@(posedge CLOCK) disable iff (!rst_n)
		$rose(state_reg == DBC_S_CAS) |-> ##1 (state_reg == DBC_S_CAS) ##1
		(state_reg == DBC_S_IDLE && MEM_ACK))
		else $error("strobe phase not two clocks");

	a_half_on_clear: assert property (@(posedge CLOCK) disable iff (!rst_n)
		CAS_HALF_EXTEND |-> !$past(mem_ctrl_reg[dbc_pkg::POS_STROBE_W]) && $past(cur_read_reg))
		else $error("half clock stretch with width bit set");

	a_protect_no_cas: assert property (@(posedge CLOCK) disable iff (!rst_n)
		state_reg == DBC_S_CAS && wp_block |=> CAS_N)
		else $error("column strobe on protected write");

	a_low_disable: assert property (@(posedge CLOCK) disable iff (!rst_n)
		state_reg == DBC_S_IDLE && MEM_REQ && low_dis |=> MEM_MISS && state_reg == DBC_S_IDLE)
		else $error("disabled low memory was decoded");

	a_bank_enable: assert property (@(posedge CLOCK) disable iff (!rst_n)
		$rose(state_reg == DBC_S_ROW) |-> bank_en[cur_bank_reg])
		else $error("cycle run on a disabled bank");

	a_io_select: assert property (@(posedge CLOCK) disable iff (!rst_n)
		state_reg == DBC_S_IDLE && !MEM_REQ && IO_CYCLE |=>
		MA_OUT[10:8] == $past(CHIP_SEL_CODE[4:2]) && DEC_LO == $past(CHIP_SEL_CODE[0]))
		else $error("chip select code not driven");

endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the DRAM bank configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
	localparam logic [15:0] MC = dbc_pkg::OFS_MEM_CTRL;
	localparam logic [15:0] EXT = dbc_pkg::OFS_SIZE_EXT;
	logic CLOCK = 1'b0, RESET_N = 1'b0, IO_WR = 1'b0, IO_RD = 1'b0, HOLD_ACK = 1'b0;
	logic MEM_REQ = 1'b0, MEM_READ = 1'b0, WRITE_PROTECT_ZONE = 1'b0, MEMORY_WRITE_STROBE_N = 1'b1;
	logic IO_CYCLE = 1'b0, PERIPH_WRITE = 1'b0;
	logic [15:0] IO_ADDR = 16'h0000, IO_WDATA = 16'h0000, IO_RDATA;
	logic [3:0] LOWER_BANK_ENABLE = 4'h0;
	dbc_pkg::dbc_even_start_t EVEN_BANK_START = '0;
	logic [1:0] LOW_DISABLE_SEL = 2'h0, CACHE_MODE;
	logic [24:0] CPU_ADDR = 25'h0, lim;
	logic [4:0] CHIP_SEL_CODE = 5'h00;
	logic [7:0] PERIPH_WDATA = 8'h00, PERIPH_RDATA, RAS_N, ras_seen, en8, pdrv = 8'h5a;
	logic [11:0] MA_OUT, MA_OE, row_seen, col_seen;
	logic IO_HIT, DEC_HI, DEC_LO, CAS_N, CAS_HALF_EXTEND, MEM_ACK, MEM_MISS, PAGE_MODE;
	logic ALT_CLOCK_ALLOWED, PARITY_PIN_INPUT, half_seen, miss, orphan;
	int n_fail = 0, tests_run = 0, cyc, cas_cnt, rcyc[4];
	int lo_b[4] = '{0, 1, 4, 5};
	int ilv_b[4] = '{8, 9, 10, 14};
	int sp[8] = '{0, 2, 4, 6, 3, 4, 5, 0};
	// Peripheral side drives the shared lines only where the block releases them
	wire [11:0] MA_IN = (MA_OE & MA_OUT) | (~MA_OE & {4'h0, pdrv});

	always #12.5 CLOCK = ~CLOCK;

	dbc_top DUT (.CLOCK, .RESET_N, .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA, .IO_RDATA, .IO_HIT,
		.LOWER_BANK_ENABLE, .EVEN_BANK_START, .LOW_DISABLE_SEL, .HOLD_ACK, .CPU_ADDR, .MEM_REQ,
		.MEM_READ, .WRITE_PROTECT_ZONE, .MEMORY_WRITE_STROBE_N, .IO_CYCLE, .CHIP_SEL_CODE,
		.PERIPH_WRITE, .PERIPH_WDATA, .PERIPH_RDATA, .MA_IN, .MA_OUT, .MA_OE, .DEC_HI, .DEC_LO,
		.RAS_N, .CAS_N, .CAS_HALF_EXTEND, .MEM_ACK, .MEM_MISS, .PAGE_MODE, .CACHE_MODE,
		.ALT_CLOCK_ALLOWED, .PARITY_PIN_INPUT);

	dbc_dram_model MODEL (.clock(CLOCK), .ras_n(RAS_N), .cas_n(CAS_N), .ma(MA_OUT),
		.row_seen(row_seen), .col_seen(col_seen), .cas_without_ras(orphan));

	// ==========================================
	// Access tasks
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Register access; for a read, d is the expected value
	task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic hit);
		@(posedge CLOCK);
		IO_ADDR <= a;
		IO_WDATA <= d;
		IO_WR <= wr;
		IO_RD <= !wr;
		@(posedge CLOCK);
		IO_WR <= 1'b0;
		IO_RD <= 1'b0;
		#1;
		`CHK(IO_HIT, hit)
		if (!wr) `CHK(IO_RDATA, d)
	endtask

	// Memory cycle; exp_ras of all ones means no bank may answer
	task automatic mem(input logic [24:0] a, input logic rd, input logic [7:0] exp_ras);
		logic done;
		done = 1'b0;
		ras_seen = 8'hff;
		cas_cnt = 0;
		half_seen = 1'b0;
		@(posedge CLOCK);
		CPU_ADDR <= a;
		MEM_READ <= rd;
		MEM_REQ <= 1'b1;
		@(posedge CLOCK);
		MEM_REQ <= 1'b0;
		for (int k = 1; k <= 12 && !done; k++) begin
			#1;
			ras_seen &= RAS_N;
			if (CAS_N === 1'b0) cas_cnt++;
			if (CAS_HALF_EXTEND === 1'b1) half_seen = 1'b1;
			if (MEM_ACK === 1'b1 || MEM_MISS === 1'b1) begin
				done = 1'b1;
				cyc = k;
				miss = MEM_MISS;
			end else @(posedge CLOCK);
		end
		if (!done) begin
			n_fail++;
			complete_run();
		end else begin
			`CHK(ras_seen, exp_ras)
			`CHK(miss, exp_ras == 8'hff)
		end
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge CLOCK);
		RESET_N <= 1'b1;
		#1;
		`CHK({RAS_N, CAS_N, ALT_CLOCK_ALLOWED, MA_OE}, {8'hff, 2'b11, 12'h000})
		repeat (3) @(posedge CLOCK);
		io(0, MC, 16'h0000, 1);
		io(0, 16'h5072, 16'h0000, 1);
		io(1, MC, 16'hffff, 1);
		io(0, MC, 16'hffff, 1);
		io(1, 16'h4872, 16'hffff, 1);
		io(0, 16'h4872, 16'hff00, 1);
		io(1, EXT, 16'hffff, 1);
		io(0, EXT, 16'h3000, 1);
		io(0, 16'h1234, 16'h0000, 0);
		io(1, 16'h4872, 16'h0000, 1);
		io(1, EXT, 16'h0000, 1);
		io(1, MC, 16'h0000, 1);
		@(posedge CLOCK);
		LOWER_BANK_ENABLE <= 4'h1;
		mem(25'h01a5c4, 0, 8'hfe);
		`CHK({row_seen[7:0], col_seen[7:0]}, 16'hd2e2)
		`CHK(cas_cnt, 2)
		@(posedge CLOCK);
		MEMORY_WRITE_STROBE_N <= 1'b0;
		WRITE_PROTECT_ZONE <= 1'b1;
		repeat (3) @(posedge CLOCK);
		mem(25'h000100, 0, 8'hfe);
		`CHK(cas_cnt, 0)
		@(posedge CLOCK);
		MEMORY_WRITE_STROBE_N <= 1'b1;
		WRITE_PROTECT_ZONE <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			io(1, MC, 16'(m) << 12, 1);
			`CHK(CACHE_MODE, 2'(m == 0 ? 0 : m - 1))
			@(posedge CLOCK);
			HOLD_ACK <= 1'b1;
			@(posedge CLOCK);
			HOLD_ACK <= 1'b0;
			@(posedge CLOCK);
			#1;
			`CHK(CACHE_MODE, 2'(m))
			`CHK({ALT_CLOCK_ALLOWED, PARITY_PIN_INPUT}, {m == 0 || m == 3, m == 2})
			mem(25'h000200, 1, 8'hfe);
			rcyc[m] = cyc;
			`CHK(half_seen, 1'b1)
		end
		`CHK(rcyc[1], rcyc[0] + 1)
		`CHK(rcyc[2], rcyc[0] + 1)
		`CHK(rcyc[3], rcyc[0] + 1)
		io(1, MC, 16'h8000, 1);
		mem(25'h000200, 1, 8'hfe);
		`CHK(half_seen, 1'b0)
		// Paired banks share one size code; each bank still decodes its own start address
		for (int p = 0; p < 4; p++) begin
			en8 = 8'h05 << lo_b[p];
			io(1, MC, (16'h0001 << ilv_b[p]) | {8'h00, en8[7:4], 4'h0}, 1);
			@(posedge CLOCK);
			LOWER_BANK_ENABLE <= en8[3:0];
			mem(25'h000000, 1, ~(8'h01 << lo_b[p]));
			mem(25'h000002, 1, ~(8'h01 << (lo_b[p] + 2)));
			mem(25'h030000, 1, ~(8'h01 << lo_b[p]));
			`CHK(PAGE_MODE, 1'b0)
		end
		io(1, MC, 16'h4800 | 16'h00a0, 1);
		mem(25'h000002, 1, 8'hdf);
		mem(25'h000200, 1, 8'h7f);
		`CHK(PAGE_MODE, 1'b1)
		@(posedge CLOCK);
		LOWER_BANK_ENABLE <= 4'h0;
		EVEN_BANK_START.b4 <= 8'h10;
		io(1, MC, 16'h0010, 1);
		mem(25'h200000, 0, 8'hef);
		mem(25'h220000, 0, 8'hff);
		io(1, EXT, 16'h2000, 1);
		io(1, MC, 16'h0013, 1);
		mem(25'h2ffffe, 0, 8'hef);
		io(1, MC, 16'h0000, 1);
		mem(25'h200000, 0, 8'hff);
		@(posedge CLOCK);
		LOWER_BANK_ENABLE <= 4'h1;
		for (int i = 0; i < 8; i++) begin
			io(1, EXT, 16'(i[2]) << 12, 1);
			io(1, MC, 16'(i[1:0]), 1);
			lim = 25'h020000 << sp[i];
			mem(lim - 25'h2, 1, i == 7 ? 8'hff : 8'hfe);
			mem(lim, 1, 8'hff);
		end
		io(1, EXT, 16'h0000, 1);
		io(1, MC, 16'h0002, 1);
		// Low memory goes off from each disable base up to 640K
		for (int s = 1; s < 4; s++) begin
			@(posedge CLOCK);
			LOW_DISABLE_SEL <= 2'(s);
			lim = 25'h010000 << s;
			mem(lim - 25'h2, 1, 8'hfe);
			mem(lim, 1, 8'hff);
			mem(25'h09fffe, 1, 8'hff);
			mem(25'h0a0000, 1, 8'hfe);
		end
		@(posedge CLOCK);
		IO_CYCLE <= 1'b1;
		PERIPH_WRITE <= 1'b1;
		for (int c = 0; c < 32; c++) begin
			@(posedge CLOCK);
			CHIP_SEL_CODE <= 5'(c);
			PERIPH_WDATA <= 8'(c * 37);
			@(posedge CLOCK);
			#1;
			`CHK({MA_OUT[10:8], DEC_HI, DEC_LO}, 5'(c))
			`CHK({MA_OE[7:0], MA_OUT[7:0]}, {8'hff, 8'(c * 37)})
		end
		@(posedge CLOCK);
		PERIPH_WRITE <= 1'b0;
		pdrv <= 8'h3c;
		repeat (5) @(posedge CLOCK);
		#1;
		`CHK({MA_OE[7:0], PERIPH_RDATA}, 16'h003c)
		`CHK(orphan, 1'b0)
		complete_run();
	end
endmodule
`default_nettype wire
